/* File: sbm_fifo.sv */
// Purpose: word fifo between burst capture and array write
// Assumes: push ignored when full, pop ignored when empty
// Notes:   level counts stored words
`timescale 1ns/1ps
`default_nettype none
module sbm_fifo
	import sbm_pkg::*;
#(
	parameter int W = $bits(sbm_entry_t),
	parameter int D = FIFO_DEPTH
) (
	input  wire logic             clk,
	input  wire logic             resetn,
	sbm_stream_if.snk             in_s,
	sbm_stream_if.src             out_s,
	output logic [$clog2(D):0]    level
);
	localparam int AW = $clog2(D);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       rd;
		logic [AW-1:0]       wr;
		logic [AW:0]         cnt;
	} sbm_fifo_st_t;

	sbm_fifo_st_t st;
	sbm_fifo_st_t next_st;
	logic         push;
	logic         pop;

	always_comb begin
		in_s.ready  = (st.cnt != (AW+1)'(D));
		out_s.valid = (st.cnt != '0);
		out_s.data  = sbm_entry_t'(st.mem[st.rd]);
		level       = st.cnt;
		push        = in_s.valid & in_s.ready;
		pop         = out_s.valid & out_s.ready;
		next_st     = st;
		if (push) begin
			next_st.mem[st.wr] = W'(in_s.data);
			next_st.wr         = st.wr + 1'b1;
		end
		if (pop) begin
			next_st.rd = st.rd + 1'b1;
		end
		next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : sbm_fifo
`default_nettype wire

/* File: sbm_mem.sv */
// Purpose: write array with per-bit enables and registered read
// Assumes: bits with enable low keep their stored value
// Notes:   read data lags the read address by one clock
`timescale 1ns/1ps
`default_nettype none
module sbm_mem
	import sbm_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic               we,
	input  wire logic [WADDR_W-1:0] waddr,
	input  wire logic [DATA_W-1:0]  wbit_en,
	input  wire logic [DATA_W-1:0]  wdata,
	input  wire logic [WADDR_W-1:0] raddr,
	output logic      [DATA_W-1:0]  rdata
);
	localparam int N = 1 << WADDR_W;

	typedef struct packed {
		logic [N-1:0][DATA_W-1:0] mem;
		logic [DATA_W-1:0]        rdata;
	} sbm_mem_st_t;

	sbm_mem_st_t st;
	sbm_mem_st_t next_st;

	always_comb begin
		next_st       = st;
		next_st.rdata = st.mem[raddr];
		if (we) begin
			next_st.mem[waddr] = (st.mem[waddr] & ~wbit_en)
				| (wdata & wbit_en);
		end
		rdata = st.rdata;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule : sbm_mem
`default_nettype wire

/* File: sbm_monitor.sv */
// Purpose: port checker for the lane mask block
// Assumes: one wait state on every APB access
// Notes:   bound to sbm_top below
`timescale 1ns/1ps
`default_nettype none
module sbm_monitor
	import sbm_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire logic [7:0] paddr,
	input wire logic       psel,
	input wire logic       penable,
	input wire logic       pready,
	input wire logic       pslverr,
	input wire logic       read_data_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	sequence acc_wait; psel && penable && !pready; endsequence
	sequence acc_done; psel && penable && pready; endsequence
	logic mapped;
	assign mapped = paddr[1:0] == 2'h0 && paddr <= REG_WCOUNT;
	oe_off_a: assert property (!read_data_oe)
		else $error("read drive on");
	ready_wait_a: assert property (acc_wait |=> acc_done)
		else $error("late answer");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready held");
	ready_cause_a: assert property (pready |-> $past(psel && penable))
		else $error("ready without access");
	setup_quiet_a: assert property (psel && !penable |-> !pready)
		else $error("ready in setup");
	err_alone_a: assert property (pslverr |-> pready)
		else $error("lone error");
	err_unmap_a: assert property (acc_done ##0 !mapped |-> pslverr)
		else $error("hole accepted");
	err_map_a: assert property (acc_done ##0 mapped |-> !pslverr)
		else $error("register refused");
endmodule : sbm_monitor
bind sbm_top sbm_monitor u_mon (.core_clk, .resetn, .paddr, .psel,
	.penable, .pready, .pslverr, .read_data_oe);
`default_nettype wire

/* File: sbm_pkg.sv */
// Purpose: shared constants and types for the byte lane write mask block
// Assumes: one 20 MHz core clock, APB register access
// Notes:   offsets are byte addresses of 32-bit registers
package sbm_pkg;
	localparam int DATA_W     = 36;
	localparam int ADDR_W     = 4;
	localparam int WADDR_W    = ADDR_W + 1;
	localparam int FIFO_DEPTH = 8;
	localparam int LVL_W      = 4;
	localparam int NIB_W      = 4;
	localparam int BYTE_W     = 9;
	localparam int LANES      = 4;

	localparam logic [1:0] ORG_X8  = 2'h0;
	localparam logic [1:0] ORG_X9  = 2'h1;
	localparam logic [1:0] ORG_X18 = 2'h2;
	localparam logic [1:0] ORG_X36 = 2'h3;

	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RADDR  = 8'h08;
	localparam logic [7:0] REG_RDLO   = 8'h0C;
	localparam logic [7:0] REG_RDHI   = 8'h10;
	localparam logic [7:0] REG_WCOUNT = 8'h14;

	localparam int CTRL_ORG_LSB  = 0;
	localparam int CTRL_HOLD_BIT = 2;
	localparam int CTRL_EN_BIT   = 3;
	localparam int STAT_BUSY_BIT = 4;
	localparam int STAT_OVF_BIT  = 5;

	localparam logic [3:0] CTRL_RST = 4'hB;

	typedef struct packed {
		logic [WADDR_W-1:0] waddr;
		logic [DATA_W-1:0]  data;
		logic [DATA_W-1:0]  bit_en;
	} sbm_entry_t;
endpackage : sbm_pkg

/* File: sbm_stream_if.sv */
// Purpose: valid/ready stream of masked write words
// Assumes: fifo source holds data while valid and not ready; capture source drops a word it cannot push
// Notes:   used between capture, fifo and array
`timescale 1ns/1ps
`default_nettype none
interface sbm_stream_if;
	import sbm_pkg::*;
	logic       valid;
	logic       ready;
	sbm_entry_t data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : sbm_stream_if
`default_nettype wire

/* File: sbm_top.sv */
// Purpose: two-word write burst capture with per-word lane masks
// Assumes: write port pins synchronous to core_clk; timing phases
//          sampled as levels and edge detected; phases rest high
//          between bursts
// Notes:   array written through an 8-word fifo; APB for control
//          refused pushes set a sticky overflow flag
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - lane selects sampled separately per word
// - x8: both nibble selects low write all
// - x8: select 0 only writes bits 3:0
// - x8: select 1 only writes bits 7:4
// - x18: both selects low write all
// - x18: one select writes its nine bits
// - x8/x18: both high write nothing
// - x9: single select writes all or nothing
// - x36: all four low write all
// - x36: select 0 alone writes bits 8:0
// - x36: selects 1-3 write their own byte
// - x36: all high write nothing
// - reset: port deselected, read drive off
// - first word offset 0, second offset 1
module sbm_top
	import sbm_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              resetn,
	input  wire logic [7:0]        paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              main_timing_pos,
	input  wire logic              main_timing_neg,
	input  wire logic              write_port_select_n,
	input  wire logic [ADDR_W-1:0] write_addr,
	input  wire logic [DATA_W-1:0] write_data,
	input  wire logic              byte_lane_enable_n_0,
	input  wire logic              byte_lane_enable_n_1,
	input  wire logic              byte_lane_enable_n_2,
	input  wire logic              byte_lane_enable_n_3,
	input  wire logic              nibble_lane_enable_n_0,
	input  wire logic              nibble_lane_enable_n_1,
	output logic                   write_ready,
	output logic                   read_data_oe
);
	typedef enum logic {
		BS_IDLE,
		BS_SECOND
	} sbm_bstate_t;

	typedef struct packed {
		logic              pos_q;
		logic              neg_q;
		sbm_bstate_t       bst;
		logic [ADDR_W-1:0] baddr;
		logic              push_v;
		sbm_entry_t        push_e;
		logic [1:0]        org;
		logic              hold;
		logic              en;
		logic              ovf;
		logic [WADDR_W-1:0] rd_addr;
		logic [15:0]       wcount;
		logic [31:0]       prdata;
		logic              pready;
		logic              pslverr;
		logic              wr_ready;
		logic              rd_oe;
	} sbm_top_st_t;

	// expand active-low lane selects into bit enables per organisation
	function automatic logic [DATA_W-1:0] lane_bits(
		input logic [1:0]       org,
		input logic [LANES-1:0] bsel_n,
		input logic [1:0]       nsel_n
	);
		logic [DATA_W-1:0] m;
		m = '0;
		case (org)
			ORG_X8: begin
				// nibble selects only; byte selects unused here
				m[NIB_W-1:0]       = {NIB_W{~nsel_n[0]}};
				m[2*NIB_W-1:NIB_W] = {NIB_W{~nsel_n[1]}};
			end
			ORG_X9: begin
				m[BYTE_W-1:0] = {BYTE_W{~bsel_n[0]}};
			end
			ORG_X18: begin
				for (int i = 0; i < 2; i++) begin
					m[i*BYTE_W +: BYTE_W] = {BYTE_W{~bsel_n[i]}};
				end
			end
			ORG_X36: begin
				// each select opens only its own nine bits
				for (int i = 0; i < LANES; i++) begin
					m[i*BYTE_W +: BYTE_W] = {BYTE_W{~bsel_n[i]}};
				end
			end
			default: m = '0;
		endcase
		// all selects high leave m zero: nothing written
		return m;
	endfunction : lane_bits

	// one map for both directions keeps reads and writes in step
	function automatic logic reg_mapped(input logic [7:0] a);
		logic ok;
		case (a)
			REG_CTRL, REG_STATUS, REG_RADDR,
			REG_RDLO, REG_RDHI, REG_WCOUNT: ok = 1'b1;
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : reg_mapped

	sbm_top_st_t       st;
	sbm_top_st_t       next_st;
	sbm_stream_if      cap_s ();
	sbm_stream_if      arr_s ();
	logic [LVL_W-1:0]  level;
	logic [DATA_W-1:0] mem_rdata;
	logic [LANES-1:0]  bsel_n;
	logic [1:0]        nsel_n;
	logic              pos_rise;
	logic              neg_rise;
	logic              drain;
	logic              apb_acc;
	logic              apb_wr;
	logic [31:0]       rd_val;
	logic              hit;
	logic              ovf_set;
	logic              start;

	sbm_fifo #(
		.W ($bits(sbm_entry_t)),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk    (core_clk),
		.resetn (resetn),
		.in_s   (cap_s),
		.out_s  (arr_s),
		.level  (level)
	);

	// read data registered: RDLO lags RADDR by one clock
	sbm_mem u_mem (
		.clk     (core_clk),
		.resetn  (resetn),
		.we      (drain),
		.waddr   (arr_s.data.waddr),
		.wbit_en (arr_s.data.bit_en),
		.wdata   (arr_s.data.data),
		.raddr   (st.rd_addr),
		.rdata   (mem_rdata)
	);

	always_comb begin
		bsel_n = {byte_lane_enable_n_3, byte_lane_enable_n_2,
			byte_lane_enable_n_1, byte_lane_enable_n_0};
		nsel_n = {nibble_lane_enable_n_1, nibble_lane_enable_n_0};
		pos_rise = main_timing_pos & ~st.pos_q;
		neg_rise = main_timing_neg & ~st.neg_q;

		cap_s.valid = st.push_v;
		cap_s.data  = st.push_e;
		// software hold stalls draining so the fifo can back up
		arr_s.ready = ~st.hold;
		drain       = arr_s.valid & arr_s.ready;

		// one wait state: pready follows the first access cycle
		apb_acc = psel & penable & ~st.pready;
		apb_wr  = psel & penable & st.pready & pwrite;

		ovf_set = st.push_v & ~cap_s.ready;
		start   = pos_rise & ~write_port_select_n & st.en;

		hit    = reg_mapped(paddr);
		rd_val = '0;
		case (paddr)
			REG_CTRL: begin
				rd_val[CTRL_ORG_LSB +: 2] = st.org;
				rd_val[CTRL_HOLD_BIT]     = st.hold;
				rd_val[CTRL_EN_BIT]       = st.en;
			end
			REG_STATUS: begin
				rd_val[LVL_W-1:0]    = level;
				rd_val[STAT_BUSY_BIT] = (st.bst == BS_SECOND);
				rd_val[STAT_OVF_BIT]  = st.ovf;
			end
			REG_RADDR: rd_val[WADDR_W-1:0] = st.rd_addr;
			REG_RDLO:  rd_val = mem_rdata[31:0];
			REG_RDHI:  rd_val[DATA_W-33:0] = mem_rdata[DATA_W-1:32];
			REG_WCOUNT: rd_val[15:0] = st.wcount;
			default:   ;
		endcase

		next_st        = st;
		next_st.pos_q  = main_timing_pos;
		next_st.neg_q  = main_timing_neg;
		next_st.push_v = 1'b0;
		next_st.rd_oe  = 1'b0;

		// a capture the fifo cannot take is dropped and flagged
		if (ovf_set) begin
			next_st.ovf = 1'b1;
		end

		case (st.bst)
			BS_IDLE: begin
				// selects outside a started burst are never sampled
				if (start) begin
					next_st.bst    = BS_SECOND;
					next_st.baddr  = write_addr;
					next_st.push_v = 1'b1;
					next_st.push_e.waddr  = {write_addr, 1'b0};
					next_st.push_e.data   = write_data;
					next_st.push_e.bit_en =
						lane_bits(st.org, bsel_n, nsel_n);
				end
			end
			BS_SECOND: begin
				// a further positive edge is refused until word two
				if (neg_rise) begin
					next_st.bst    = BS_IDLE;
					next_st.push_v = 1'b1;
					next_st.push_e.waddr  = {st.baddr, 1'b1};
					next_st.push_e.data   = write_data;
					// fresh sample: second word may carry another mask
					next_st.push_e.bit_en =
						lane_bits(st.org, bsel_n, nsel_n);
				end
			end
			default: next_st.bst = BS_IDLE;
		endcase

		// words with every lane closed still count as drained
		if (drain) begin
			next_st.wcount = st.wcount + 16'h0001;
		end

		// write commits on the edge where pready is seen high
		if (apb_wr && reg_mapped(paddr)) begin
			case (paddr)
				REG_CTRL: begin
					next_st.org  = pwdata[CTRL_ORG_LSB +: 2];
					next_st.hold = pwdata[CTRL_HOLD_BIT];
					next_st.en   = pwdata[CTRL_EN_BIT];
				end
				REG_STATUS: begin
					// a new overflow in the same cycle wins
					if (pwdata[STAT_OVF_BIT] && !ovf_set) begin
						next_st.ovf = 1'b0;
					end
				end
				REG_RADDR: next_st.rd_addr = pwdata[WADDR_W-1:0];
				default: ;
			endcase
		end

		next_st.pready = apb_acc;
		if (apb_acc) begin
			next_st.prdata  = pwrite ? 32'h0000_0000 : rd_val;
			next_st.pslverr = ~hit;
		end else begin
			next_st.pslverr = 1'b0;
		end

		// slack of two: a burst already in flight still fits
		next_st.wr_ready = (level < LVL_W'(FIFO_DEPTH - 2));
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			st      <= '0;
			st.org  <= CTRL_RST[CTRL_ORG_LSB +: 2];
			st.hold <= CTRL_RST[CTRL_HOLD_BIT];
			st.en   <= CTRL_RST[CTRL_EN_BIT];
			st.bst  <= BS_IDLE;
			// phases rest high: a low reset value would fake an edge
			st.pos_q <= 1'b1;
			st.neg_q <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// every output comes straight from a state flop
	assign prdata       = st.prdata;
	assign pready       = st.pready;
	assign pslverr      = st.pslverr;
	assign write_ready  = st.wr_ready;
	assign read_data_oe = st.rd_oe;
endmodule : sbm_top
`default_nettype wire

/* File: sbm_wr_ctl.sv */
// Purpose: write port controller model
// Assumes: phases rest high between bursts
// Notes:   released lines carry inverted values
`timescale 1ns/1ps
`default_nettype none
module sbm_wr_ctl
	import sbm_pkg::*;
(
	input  wire logic         clk,
	output logic              pos,
	output logic              neg,
	output logic              sel_n,
	output logic [ADDR_W-1:0] addr,
	output logic [DATA_W-1:0] data,
	output logic [LANES-1:0]  bsel_n,
	output logic [1:0]        nsel_n
);
	// resting high gives the quickest restart
	initial begin
		pos = 1'b1;
		neg = 1'b1;
		sel_n = 1'b1;
		addr = '0;
		data = '0;
		bsel_n = '1;
		nsel_n = '1;
	end
	task automatic put(input logic [DATA_W-1:0] d, input logic [3:0] m);
		data <= d;
		bsel_n <= m;
		nsel_n <= m[1:0];
		@(posedge clk);
		data <= ~d;
		bsel_n <= ~m;
		nsel_n <= ~m[1:0];
	endtask : put
	task automatic burst(input logic go, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d0, input logic [3:0] m0,
		input logic [DATA_W-1:0] d1, input logic [3:0] m1);
		@(posedge clk);
		pos <= 1'b0;
		@(posedge clk);
		pos <= 1'b1;
		sel_n <= !go;
		addr <= a;
		put(d0, m0);
		sel_n <= 1'b1;
		addr <= ~a;
		neg <= 1'b0;
		@(posedge clk);
		neg <= 1'b1;
		put(d1, m1);
	endtask : burst
endmodule : sbm_wr_ctl
`default_nettype wire

/* File: testbench.sv */
// Purpose: self-checking bench for the lane mask block
// Assumes: array and fifo modelled in the bench
// Notes:   every mask code sent in every organisation
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import sbm_pkg::*;
	logic              core_clk = 1'b0, resetn = 1'b0;
	logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]        paddr = '0;
	logic [31:0]       pwdata = '0, prdata, rd;
	logic              pready, pslverr, write_ready, read_data_oe, err;
	logic              pos, neg, sel_n, hold = 1'b0;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] data;
	logic [LANES-1:0]  bs;
	logic [1:0]        ns, org;
	logic [DATA_W-1:0] mem_m [32];
	sbm_entry_t        q [$];
	int                n_mismatch = 0, compares = 0, cyc = 0, n_wr = 0;
	sbm_top DUT (.core_clk, .resetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .prdata, .pready, .pslverr, .main_timing_pos(pos),
		.main_timing_neg(neg), .write_port_select_n(sel_n),
		.write_addr(addr), .write_data(data), .byte_lane_enable_n_0(bs[0]),
		.byte_lane_enable_n_1(bs[1]), .byte_lane_enable_n_2(bs[2]),
		.byte_lane_enable_n_3(bs[3]), .nibble_lane_enable_n_0(ns[0]),
		.nibble_lane_enable_n_1(ns[1]), .write_ready, .read_data_oe);
	sbm_wr_ctl ctl (.clk(core_clk), .pos, .neg, .sel_n, .addr, .data,
		.bsel_n(bs), .nsel_n(ns));
	initial begin
		forever #25 core_clk = ~core_clk;
	end
	task automatic stop_test();
		if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : stop_test
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 12000) begin
			n_mismatch++;
			stop_test();
		end
	end
	task automatic check(input logic [35:0] s, input logic [35:0] e);
		compares++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: %h not %h", $time, s, e);
		end
	endtask : check
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check({4'h0, rd}, {4'h0, e});
	endtask : rchk
	function automatic logic [35:0] lane_en(input logic [3:0] m);
		logic [35:0] e;
		e = '0;
		case (org)
			ORG_X8: e[7:0] = {{4{!m[1]}}, {4{!m[0]}}};
			ORG_X9: e[8:0] = {9{!m[0]}};
			ORG_X18: e[17:0] = {{9{!m[1]}}, {9{!m[0]}}};
			default: e = {{9{!m[3]}}, {9{!m[2]}}, {9{!m[1]}}, {9{!m[0]}}};
		endcase
		return e;
	endfunction : lane_en
	function automatic void wr(input sbm_entry_t x);
		mem_m[x.waddr] = (mem_m[x.waddr] & ~x.bit_en) | (x.data & x.bit_en);
		n_wr++;
	endfunction : wr
	task automatic model(input logic [4:0] i, input logic [35:0] d,
		input logic [3:0] m);
		sbm_entry_t x;
		x = '{waddr: i, data: d, bit_en: lane_en(m)};
		if (!hold) wr(x);
		else if (q.size() < FIFO_DEPTH) q.push_back(x);
	endtask : model
	task automatic burst(input logic go, input logic [3:0] m0);
		logic [ADDR_W-1:0] a;
		logic [DATA_W-1:0] d0, d1;
		logic [3:0]        m1;
		a = ADDR_W'($urandom);
		d0 = {4'($urandom), $urandom};
		d1 = {4'($urandom), $urandom};
		m1 = 4'($urandom);
		ctl.burst(go, a, d0, m0, d1, m1);
		if (go) begin
			model({a, 1'b0}, d0, m0);
			model({a, 1'b1}, d1, m1);
		end
		repeat (4) @(posedge core_clk);
	endtask : burst
	task automatic arr_chk();
		for (int i = 0; i < 32; i++) begin
			apb(1'b1, REG_RADDR, i);
			rchk(REG_RDLO, mem_m[i][31:0]);
			rchk(REG_RDHI, {28'h0, mem_m[i][35:32]});
		end
	endtask : arr_chk
	initial begin
		void'($urandom(32'hC57F2CDC));
		foreach (mem_m[i]) mem_m[i] = '0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
		check({35'h0, read_data_oe}, 36'h0);
		rchk(REG_CTRL, {28'h0, CTRL_RST});
		rchk(REG_STATUS, 32'h0);
		apb(1'b1, 8'h18, 32'hFFFFFFFF);
		check({35'h0, err}, 36'h1);
		for (int o = 0; o < 4; o++) begin
			org = o[1:0];
			apb(1'b1, REG_CTRL, {28'h0, 2'h2, org});
			for (int i = 0; i < 16; i++) burst(1'b1, i[3:0]);
			// stray selects with no start
			burst(1'b0, 4'h0);
			// capture disabled: even a proper start must leave the array
			apb(1'b1, REG_CTRL, {28'h0, 2'h0, org});
			ctl.burst(1'b1, 4'h0, '1, 4'h0, '1, 4'h0);
			arr_chk();
		end
		// drain held back so the fifo fills and refuses
		hold = 1'b1;
		apb(1'b1, REG_CTRL, 32'hF);
		repeat (5) burst(1'b1, 4'h0);
		check({35'h0, write_ready}, 36'h0);
		rchk(REG_STATUS, 32'h28);
		apb(1'b1, REG_STATUS, 32'h20);
		apb(1'b1, REG_CTRL, 32'hB);
		hold = 1'b0;
		while (q.size() > 0) wr(q.pop_front());
		repeat (12) @(posedge core_clk);
		check({35'h0, write_ready}, 36'h1);
		rchk(REG_STATUS, 32'h0);
		arr_chk();
		rchk(REG_WCOUNT, 32'(n_wr));
		stop_test();
	end
endmodule : testbench
`default_nettype wire
